/* File: hdl/ubsp_pkg.sv */
// Shared constants and types for the serial host port of the USB bridge.
// Assumes both ends run on one 20 MHz clock and sample the link pins.
package ubsp_pkg;

  // ***********************************************************
  // Word layout
  // ***********************************************************
  localparam int unsigned WORD_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [7:0] WORD_ZERO = 8'h00;

  // Target field of the in-transfer header word, and the FIFO addresses.
  localparam int unsigned ADDR_LSB = 4;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] CTRL_FIFO_ADDR = 4'h0;
  localparam logic [3:0] DATA_FIFO_ADDR_LO = 4'h1;
  localparam logic [3:0] DATA_FIFO_ADDR_HI = 4'h2;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned SCK_HALF_NS = 500;
  localparam int unsigned SCK_HALF_CYC_I = SCK_HALF_NS / CLK_NS;
  localparam logic [3:0] SCK_HALF_CYC = 4'(SCK_HALF_CYC_I);
  localparam logic [3:0] HALF_LAST = 4'(SCK_HALF_CYC_I - 1);

  // ***********************************************************
  // Host command codes and pulse counts
  // ***********************************************************
  localparam logic [1:0] OP_STATUS = 2'h0;
  localparam logic [1:0] OP_OUT = 2'h1;
  localparam logic [1:0] OP_IN = 2'h2;
  localparam logic [1:0] STATUS_PULSES = 2'h1;
  localparam logic [1:0] COUNT_PULSES = 2'h2;

  typedef enum logic [1:0] {
    UBSP_M_IDLE = 2'b00,
    UBSP_M_STATUS = 2'b01,
    UBSP_M_OUT = 2'b10,
    UBSP_M_IN = 2'b11
  } ubsp_mode_e;

  typedef enum logic [2:0] {
    UBSP_H_IDLE = 3'b000,
    UBSP_H_PULSE_HI = 3'b001,
    UBSP_H_PULSE_LO = 3'b010,
    UBSP_H_DIR_UP = 3'b011,
    UBSP_H_BIT_LO = 3'b100,
    UBSP_H_BIT_HI = 3'b101,
    UBSP_H_END_UP = 3'b110,
    UBSP_H_END_DN = 3'b111
  } ubsp_hstate_e;

endpackage

/* File: hdl/ubsp_if.sv */
// Link between the host end and the bridge end of the serial port.
// Assumes the host drives clock, direction and data-in; weak pulldowns
// hold each of them low whenever the host releases it.
`timescale 1ns/1ns
interface ubsp_if;
  logic sck;
  logic sck_oe_n;
  logic dir_sel;
  logic dir_oe_n;
  logic h2b;
  logic h2b_oe_n;
  logic sck_pin;
  logic transfer_direction_select;
  logic host_to_bridge_data;
  logic bridge_to_host_data;

  // ***********************************************************
  // Pin levels with weak pulldowns
  // ***********************************************************
  assign sck_pin = !sck_oe_n && sck;
  assign transfer_direction_select = !dir_oe_n && dir_sel;
  assign host_to_bridge_data = !h2b_oe_n && h2b;

  modport host (
    output sck,
    output sck_oe_n,
    output dir_sel,
    output dir_oe_n,
    output h2b,
    output h2b_oe_n,
    input bridge_to_host_data
  );

  modport bridge (
    input sck_pin,
    input transfer_direction_select,
    input host_to_bridge_data,
    output bridge_to_host_data
  );
endinterface

/* File: hdl/ubsp_host.sv */
// Host end of the serial port: makes the shift clock and runs transfers.
// Assumes one command at a time from same-clock user logic.
`timescale 1ns/1ns
module ubsp_host
  import ubsp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  ubsp_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [7:0] cmd_count,
  input wire logic [7:0] wr_byte,
  output logic wr_take,
  output logic [7:0] rd_byte,
  output logic rd_valid,
  output logic irq_n
);

  ubsp_hstate_e state;
  logic [3:0] div_cnt;
  logic tick;
  logic [1:0] b2h_s;
  logic [1:0] pulses_left;
  logic [7:0] bytes_left;
  logic [2:0] bit_cnt;
  logic [7:0] tx_sreg;
  logic [7:0] rx_sreg;
  logic writing;

  // ***********************************************************
  // Shift clock divider and pin release
  // ***********************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 4'h0;
    end else if (tick) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  assign tick = (div_cnt == HALF_LAST);
  assign cmd_ready = (state == UBSP_H_IDLE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.sck_oe_n <= 1'b1;
      link.dir_oe_n <= 1'b1;
      link.h2b_oe_n <= 1'b1;
    end else begin
      link.sck_oe_n <= 1'b0;
      link.dir_oe_n <= 1'b0;
      link.h2b_oe_n <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      b2h_s <= 2'h0;
      irq_n <= 1'b1;
    end else begin
      b2h_s <= {b2h_s[0], link.bridge_to_host_data};
      irq_n <= link.dir_sel ? b2h_s[1] : 1'b1;
    end
  end

  // ***********************************************************
  // Transfer sequencer
  // ***********************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= UBSP_H_IDLE;
      link.sck <= 1'b0;
      link.dir_sel <= 1'b0;
      link.h2b <= 1'b0;
      pulses_left <= 2'h0;
      bytes_left <= 8'h00;
      bit_cnt <= BIT_FIRST;
      tx_sreg <= WORD_ZERO;
      rx_sreg <= WORD_ZERO;
      writing <= 1'b0;
      wr_take <= 1'b0;
      rd_byte <= WORD_ZERO;
      rd_valid <= 1'b0;
    end else begin
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      case (state)
        UBSP_H_IDLE: begin
          if (cmd_valid) begin
            bytes_left <= cmd_count;
            bit_cnt <= BIT_FIRST;
            writing <= (cmd_op == OP_IN);
            if (cmd_op == OP_IN) begin
              link.dir_sel <= 1'b1;
              tx_sreg <= wr_byte;
              wr_take <= 1'b1;
              state <= UBSP_H_DIR_UP;
            end else begin
              pulses_left <= (cmd_op == OP_OUT) ? COUNT_PULSES
                                                : STATUS_PULSES;
              link.h2b <= 1'b1;
              state <= UBSP_H_PULSE_HI;
            end
          end
        end
        UBSP_H_PULSE_HI: begin
          if (tick) begin
            link.h2b <= 1'b0;
            pulses_left <= pulses_left - 2'h1;
            state <= UBSP_H_PULSE_LO;
          end
        end
        UBSP_H_PULSE_LO: begin
          if (tick) begin
            if (pulses_left != 2'h0) begin
              link.h2b <= 1'b1;
              state <= UBSP_H_PULSE_HI;
            end else begin
              state <= UBSP_H_BIT_LO;
            end
          end
        end
        UBSP_H_DIR_UP: begin
          if (tick) begin
            state <= UBSP_H_BIT_LO;
          end
        end
        UBSP_H_BIT_LO: begin
          if (tick) begin
            link.sck <= 1'b1;
            if (writing) begin
              link.h2b <= tx_sreg[0];
              tx_sreg <= tx_sreg >> 1;
            end
            state <= UBSP_H_BIT_HI;
          end
        end
        UBSP_H_BIT_HI: begin
          if (tick) begin
            link.sck <= 1'b0;
            rx_sreg <= {b2h_s[1], rx_sreg[7:1]};
            bit_cnt <= bit_cnt + 3'h1;
            state <= UBSP_H_BIT_LO;
            if (bit_cnt == BIT_LAST) begin
              bytes_left <= bytes_left - 8'h01;
              if (!writing) begin
                rd_byte <= {b2h_s[1], rx_sreg[7:1]};
                rd_valid <= 1'b1;
              end
              if (bytes_left <= 8'h01) begin
                state <= writing ? UBSP_H_END_DN : UBSP_H_END_UP;
              end else if (writing) begin
                tx_sreg <= wr_byte;
                wr_take <= 1'b1;
              end
            end
          end
        end
        UBSP_H_END_UP: begin
          if (tick) begin
            link.dir_sel <= 1'b1;
            state <= UBSP_H_END_DN;
          end
        end
        UBSP_H_END_DN: begin
          if (tick) begin
            link.dir_sel <= 1'b0;
            link.h2b <= 1'b0;
            state <= UBSP_H_IDLE;
          end
        end
        default: begin
          state <= UBSP_H_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: hdl/ubsp_bridge.sv */
// Bridge end of the serial host port: shifts status, out data and in
// data, keeps the completion flags and the interrupt latch.
// Assumes the USB side gives flag set pulses and FIFO words on clk, and
// that all link pins are asynchronous to clk.
`timescale 1ns/1ns
// How it works
// - Host makes the shift clock for every bit.
// - Bridge moves next out bit at clock rise.
// - Host samples out data at clock fall.
// - Bridge captures in data at clock fall.
// - Host changes in data at clock rise.
// - Direction low means bridge sends to host.
// - Direction rise ends read, clears out flag.
// - Direction high means host sends to bridge.
// - Direction high puts interrupt on out pin.
// - Direction fall ends write, clears FIFO flag.
// - Direction rise starts write; clock pulses shift.
// - First written word holds target and count.
// - One data-in pulse loads status word.
// - Two data-in pulses load out count word.
// - Idle low direction shows status bit zero.
// - Flag rises set latch; interrupt is NOR.
// - Status read clears the interrupt latch.
module ubsp_bridge
  import ubsp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  ubsp_if.bridge link,
  input wire logic [7:0] bridge_status_word,
  input wire logic [7:0] out_byte_count_word,
  input wire logic [7:0] out_fifo_byte,
  output logic out_fifo_take,
  output logic [7:0] in_target_and_count_word,
  output logic in_target_valid,
  output logic [7:0] in_data_byte,
  output logic in_data_valid,
  input wire logic out_done_set,
  input wire logic ctrl_in_done_set,
  input wire logic data_in_done_set,
  input wire logic resume,
  input wire logic usb_reset,
  output logic out_complete_flag,
  output logic control_in_complete_flag,
  output logic data_in_complete_flag,
  output logic int_latch
);

  ubsp_mode_e mode;
  logic [1:0] sck_s;
  logic [1:0] dir_s;
  logic [1:0] sdi_s;
  logic sck_q;
  logic dir_q;
  logic sdi_q;
  logic sck_rise;
  logic sck_fall;
  logic dir_rise;
  logic dir_fall;
  logic sdi_fall;
  logic status_load;
  logic [7:0] tx_sreg;
  logic [7:0] rx_sreg;
  logic [7:0] next_rx;
  logic [2:0] bit_cnt;
  logic shift_pend;
  logic first_in;
  logic addr_seen;
  logic [3:0] target;
  logic hit_ctrl;
  logic hit_data;
  logic out_prev;
  logic ctrl_prev;
  logic data_prev;
  logic flag_rise;
  logic int_n;

  // ***********************************************************
  // Pin synchronisers and edge detection
  // ***********************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_s <= 2'h0;
      dir_s <= 2'h0;
      sdi_s <= 2'h0;
      sck_q <= 1'b0;
      dir_q <= 1'b0;
      sdi_q <= 1'b0;
    end else begin
      sck_s <= {sck_s[0], link.sck_pin};
      dir_s <= {dir_s[0], link.transfer_direction_select};
      sdi_s <= {sdi_s[0], link.host_to_bridge_data};
      sck_q <= sck_s[1];
      dir_q <= dir_s[1];
      sdi_q <= sdi_s[1];
    end
  end

  assign sck_rise = sck_s[1] && !sck_q;
  assign sck_fall = !sck_s[1] && sck_q;
  assign dir_rise = dir_s[1] && !dir_q;
  assign dir_fall = !dir_s[1] && dir_q;
  // A data-in fall that lands with the direction fall is no status pulse.
  assign sdi_fall = !sdi_s[1] && sdi_q && !dir_s[1] && !dir_q;
  // A pulse reads the status word unless it is the second of a pair.
  assign status_load = sdi_fall && (mode != UBSP_M_STATUS);
  assign next_rx = {sdi_s[1], rx_sreg[7:1]};

  // ***********************************************************
  // Transfer engine
  // ***********************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode <= UBSP_M_IDLE;
      tx_sreg <= WORD_ZERO;
      rx_sreg <= WORD_ZERO;
      bit_cnt <= BIT_FIRST;
      shift_pend <= 1'b0;
      first_in <= 1'b0;
      addr_seen <= 1'b0;
      out_fifo_take <= 1'b0;
      in_target_and_count_word <= WORD_ZERO;
      in_target_valid <= 1'b0;
      in_data_byte <= WORD_ZERO;
      in_data_valid <= 1'b0;
    end else begin
      out_fifo_take <= 1'b0;
      in_target_valid <= 1'b0;
      in_data_valid <= 1'b0;
      if (dir_rise) begin
        mode <= UBSP_M_IN;
        bit_cnt <= BIT_FIRST;
        first_in <= 1'b1;
        addr_seen <= 1'b0;
      end else if (dir_fall) begin
        mode <= UBSP_M_IDLE;
        tx_sreg <= bridge_status_word;
      end else begin
        case (mode)
          UBSP_M_IDLE: begin
            tx_sreg <= bridge_status_word;
            if (status_load) begin
              mode <= UBSP_M_STATUS;
              bit_cnt <= BIT_FIRST;
              shift_pend <= 1'b0;
            end
          end
          UBSP_M_STATUS, UBSP_M_OUT: begin
            if (sdi_fall) begin
              bit_cnt <= BIT_FIRST;
              shift_pend <= 1'b0;
              if (mode == UBSP_M_STATUS) begin
                mode <= UBSP_M_OUT;
                tx_sreg <= out_byte_count_word;
              end else begin
                mode <= UBSP_M_STATUS;
                tx_sreg <= bridge_status_word;
              end
            end else if (sck_fall) begin
              shift_pend <= 1'b1;
            end else if (sck_rise && shift_pend) begin
              shift_pend <= 1'b0;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt != BIT_LAST) begin
                tx_sreg <= tx_sreg >> 1;
              end else if (mode == UBSP_M_OUT) begin
                tx_sreg <= out_fifo_byte;
                out_fifo_take <= 1'b1;
              end else begin
                tx_sreg <= WORD_ZERO;
              end
            end
          end
          UBSP_M_IN: begin
            if (sck_fall) begin
              rx_sreg <= next_rx;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == BIT_LAST) begin
                first_in <= 1'b0;
                if (first_in) begin
                  in_target_and_count_word <= next_rx;
                  in_target_valid <= 1'b1;
                  addr_seen <= 1'b1;
                end else begin
                  in_data_byte <= next_rx;
                  in_data_valid <= 1'b1;
                end
              end
            end
          end
          default: begin
            mode <= UBSP_M_IDLE;
          end
        endcase
      end
    end
  end

  // ***********************************************************
  // Completion flags; a set in the clearing cycle wins
  // ***********************************************************
  assign target = in_target_and_count_word[ADDR_LSB +: ADDR_W];
  assign hit_ctrl = addr_seen && (target == CTRL_FIFO_ADDR);
  assign hit_data = addr_seen && (target >= DATA_FIFO_ADDR_LO)
                    && (target <= DATA_FIFO_ADDR_HI);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_complete_flag <= 1'b0;
      control_in_complete_flag <= 1'b0;
      data_in_complete_flag <= 1'b0;
    end else begin
      if (out_done_set) begin
        out_complete_flag <= 1'b1;
      end else if (dir_rise) begin
        out_complete_flag <= 1'b0;
      end
      if (ctrl_in_done_set) begin
        control_in_complete_flag <= 1'b1;
      end else if (dir_fall && hit_ctrl) begin
        control_in_complete_flag <= 1'b0;
      end
      if (data_in_done_set) begin
        data_in_complete_flag <= 1'b1;
      end else if (dir_fall && hit_data) begin
        data_in_complete_flag <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // Interrupt latch and the shared output pin
  // ***********************************************************
  assign flag_rise = (out_complete_flag && !out_prev)
                     || (control_in_complete_flag && !ctrl_prev)
                     || (data_in_complete_flag && !data_prev);
  assign int_n = !(int_latch || resume || usb_reset);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_prev <= 1'b0;
      ctrl_prev <= 1'b0;
      data_prev <= 1'b0;
      int_latch <= 1'b0;
    end else begin
      out_prev <= out_complete_flag;
      ctrl_prev <= control_in_complete_flag;
      data_prev <= data_in_complete_flag;
      if (flag_rise) begin
        int_latch <= 1'b1;
      end else if (status_load) begin
        int_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.bridge_to_host_data <= 1'b0;
    end else if (dir_s[1]) begin
      link.bridge_to_host_data <= int_n;
    end else begin
      link.bridge_to_host_data <= tx_sreg[0];
    end
  end

endmodule

/* File: tb/ubsp_monitor.sv */
// Concurrent checks on the link between host end and bridge end.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ns
module ubsp_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck_oe_n,
  input wire logic dir_oe_n,
  input wire logic h2b_oe_n,
  input wire logic sck_pin,
  input wire logic transfer_direction_select,
  input wire logic host_to_bridge_data,
  input wire logic bridge_to_host_data,
  input wire logic resume,
  input wire logic usb_reset,
  input wire logic out_done_set,
  input wire logic ctrl_in_done_set,
  input wire logic data_in_done_set,
  input wire logic out_complete_flag,
  input wire logic control_in_complete_flag,
  input wire logic data_in_complete_flag,
  input wire logic int_latch
);
  // ***********************************************************
  // Sequences
  // ***********************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic no_set;
  assign no_set = !out_done_set && !ctrl_in_done_set && !data_in_done_set;
  sequence quiet_s;
    no_set [*8];
  endsequence
  sequence irq_steady_s;
    (transfer_direction_select && $stable(int_latch) && $stable(resume)
      && $stable(usb_reset)) [*8];
  endsequence
  sequence status_pulse_s;
    !transfer_direction_select && !$past(transfer_direction_select, 1)
      && $fell(host_to_bridge_data);
  endsequence
  // ***********************************************************
  // Assertions
  // ***********************************************************
  sck_pulldown_a: assert property (sck_oe_n |-> !sck_pin)
    else $error("released clock pin not low");
  dir_pulldown_a: assert property (
    dir_oe_n |-> !transfer_direction_select)
    else $error("released direction pin not low");
  sdi_pulldown_a: assert property (
    h2b_oe_n |-> !host_to_bridge_data)
    else $error("released data-in pin not low");
  out_bit_hold_a: assert property (
    !transfer_direction_select && $fell(sck_pin)
      |-> $stable(bridge_to_host_data))
    else $error("out bit moved at clock fall");
  irq_pin_a: assert property (
    transfer_direction_select [*8] ##1 irq_steady_s
      |-> bridge_to_host_data == !(int_latch || resume || usb_reset))
    else $error("interrupt pin wrong while direction high");
  latch_set_a: assert property (
    $rose(out_complete_flag) || $rose(control_in_complete_flag)
      || $rose(data_in_complete_flag) |-> ##[0:2] int_latch)
    else $error("interrupt latch not set by flag rise");
  out_flag_clear_a: assert property (
    $rose(transfer_direction_select) ##0 quiet_s |-> !out_complete_flag)
    else $error("out flag not cleared by direction rise");
  read_clear_a: assert property (
    status_pulse_s ##0 quiet_s |-> !int_latch)
    else $error("interrupt latch not cleared by status read");
endmodule

/* File: tb/tb_usb_bridge_serial_host_port.sv */
// Bench joining host end and bridge end through the link interface.
// Assumes one 20 MHz clock for both ends and the link checker beside it.
`timescale 1ns/1ns
module tb_usb_bridge_serial_host_port;
  import ubsp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = OP_STATUS;
  logic [7:0] cmd_count = 8'h01;
  logic [7:0] wr_byte = 8'h00;
  logic [7:0] status_word = 8'h00;
  logic [7:0] count_word = 8'h00;
  logic [7:0] fifo_byte = 8'h00;
  logic out_set = 1'b0;
  logic ctrl_set = 1'b0;
  logic data_set = 1'b0;
  logic resume = 1'b0;
  logic usb_reset = 1'b0;
  logic cmd_ready, wr_take, rd_valid, irq_n, out_fifo_take;
  logic in_target_valid, in_data_valid, out_flag, ctrl_flag, data_flag;
  logic int_latch, irq_seen;
  logic [7:0] rd_byte, tgt, in_data_byte, tgt_word;
  logic [7:0] wbuf [2];
  logic [7:0] rdq [$];
  logic [7:0] inq [$];
  int wi = 0;
  int takes = 0;
  int failures = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  ubsp_if ubsp_if_i ();
  ubsp_host ubsp_host_i (.clk(clk), .rstn(rstn), .link(ubsp_if_i),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_count(cmd_count), .wr_byte(wr_byte), .wr_take(wr_take),
    .rd_byte(rd_byte), .rd_valid(rd_valid), .irq_n(irq_n));
  ubsp_bridge ubsp_bridge_i (.clk(clk), .rstn(rstn), .link(ubsp_if_i),
    .bridge_status_word(status_word), .out_byte_count_word(count_word),
    .out_fifo_byte(fifo_byte), .out_fifo_take(out_fifo_take),
    .in_target_and_count_word(tgt), .in_target_valid(in_target_valid),
    .in_data_byte(in_data_byte), .in_data_valid(in_data_valid),
    .out_done_set(out_set), .ctrl_in_done_set(ctrl_set),
    .data_in_done_set(data_set), .resume(resume), .usb_reset(usb_reset),
    .out_complete_flag(out_flag), .control_in_complete_flag(ctrl_flag),
    .data_in_complete_flag(data_flag), .int_latch(int_latch));
  ubsp_monitor ubsp_monitor_i (.clk(clk), .rstn(rstn),
    .sck_oe_n(ubsp_if_i.sck_oe_n), .dir_oe_n(ubsp_if_i.dir_oe_n),
    .h2b_oe_n(ubsp_if_i.h2b_oe_n), .sck_pin(ubsp_if_i.sck_pin),
    .transfer_direction_select(ubsp_if_i.transfer_direction_select),
    .host_to_bridge_data(ubsp_if_i.host_to_bridge_data),
    .bridge_to_host_data(ubsp_if_i.bridge_to_host_data),
    .resume(resume), .usb_reset(usb_reset), .out_done_set(out_set),
    .ctrl_in_done_set(ctrl_set), .data_in_done_set(data_set),
    .out_complete_flag(out_flag), .control_in_complete_flag(ctrl_flag),
    .data_in_complete_flag(data_flag), .int_latch(int_latch));
  // ***********************************************************
  // Capture and helpers
  // ***********************************************************
  always @(posedge clk) begin
    if (rd_valid === 1'b1) rdq.push_back(rd_byte);
    if (in_data_valid === 1'b1) inq.push_back(in_data_byte);
    if (in_target_valid === 1'b1) tgt_word = tgt;
    if (out_fifo_take === 1'b1) takes++;
    if (wr_take === 1'b1) begin
      wi++;
      #2 wr_byte = wbuf[wi % 2];
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic do_cmd(input logic [1:0] op, input logic [7:0] cnt,
      input logic [7:0] b0, input logic [7:0] b1);
    int n;
    rdq.delete();
    inq.delete();
    wbuf[0] = b0;
    wbuf[1] = b1;
    wi = 0;
    tick(1);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_count = cnt;
    wr_byte = b0;
    tick(1);
    cmd_valid = 1'b0;
    n = 0;
    if (op == OP_IN) begin
      while (ubsp_if_i.transfer_direction_select !== 1'b1 && n < 50) begin
        tick(1);
        n++;
      end
      tick(15);
      irq_seen = irq_n;
    end
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    chk("cmd_ready", 8'h01, {7'h0, cmd_ready});
    tick(10);
  endtask
  function automatic logic [7:0] flags();
    return {5'h0, out_flag, ctrl_flag, data_flag};
  endfunction
  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_idle_pin();
    status_word = 8'h4d;
    tick(8);
    chk("idle pin", 8'h01, {7'h0, ubsp_if_i.bridge_to_host_data});
    status_word = 8'h4c;
    tick(8);
    chk("idle pin", 8'h00, {7'h0, ubsp_if_i.bridge_to_host_data});
  endtask
  task automatic t_latch_set();
    out_set = 1'b1;
    ctrl_set = 1'b1;
    data_set = 1'b1;
    tick(1);
    out_set = 1'b0;
    ctrl_set = 1'b0;
    data_set = 1'b0;
    tick(4);
    chk("flags", 8'h07, flags());
    chk("int_latch", 8'h01, {7'h0, int_latch});
  endtask
  task automatic t_write_plain();
    do_cmd(OP_IN, 8'h02, 8'h51, 8'h3c);
    chk("irq_n", 8'h00, {7'h0, irq_seen});
    chk("target word", 8'h51, tgt_word);
    chk("in count", 8'h01, 8'(inq.size()));
    chk("in byte", 8'h3c, inq[0]);
    chk("flags", 8'h03, flags());
  endtask
  task automatic t_fifo_writes();
    logic [7:0] hdr [2];
    logic [7:0] exp [2];
    hdr = '{8'h01, 8'h21};
    exp = '{8'h01, 8'h00};
    for (int i = 0; i < 2; i++) begin
      do_cmd(OP_IN, 8'h02, hdr[i], 8'hc3);
      chk("in byte", 8'hc3, inq[0]);
      chk("flags", exp[i], flags());
    end
    chk("int_latch", 8'h01, {7'h0, int_latch});
  endtask
  task automatic t_out_read();
    count_word = 8'h81;
    fifo_byte = 8'h96;
    takes = 0;
    out_set = 1'b1;
    tick(1);
    out_set = 1'b0;
    do_cmd(OP_OUT, 8'h02, 8'h00, 8'h00);
    chk("count word", 8'h81, rdq[0]);
    chk("out byte", 8'h96, rdq[1]);
    chk("fifo take", 8'h01, {7'h0, takes > 0});
    chk("flags", 8'h00, flags());
  endtask
  task automatic t_status_read();
    out_set = 1'b1;
    tick(1);
    out_set = 1'b0;
    tick(4);
    chk("int_latch", 8'h01, {7'h0, int_latch});
    status_word = 8'ha6;
    do_cmd(OP_STATUS, 8'h01, 8'h00, 8'h00);
    chk("status word", 8'ha6, rdq[0]);
    chk("int_latch", 8'h00, {7'h0, int_latch});
    resume = 1'b1;
    do_cmd(OP_IN, 8'h01, 8'h51, 8'h00);
    chk("irq_n", 8'h00, {7'h0, irq_seen});
    resume = 1'b0;
    usb_reset = 1'b1;
    do_cmd(OP_IN, 8'h01, 8'h51, 8'h00);
    chk("irq_n", 8'h00, {7'h0, irq_seen});
    usb_reset = 1'b0;
    do_cmd(OP_IN, 8'h01, 8'h51, 8'h00);
    chk("irq_n", 8'h01, {7'h0, irq_seen});
  endtask
  // ***********************************************************
  // Main sequence and watchdog
  // ***********************************************************
  initial begin
    tick(20);
    rstn = 1'b1;
    t_idle_pin();
    t_latch_set();
    t_write_plain();
    t_fifo_writes();
    t_out_read();
    t_status_read();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
